// >>> logic/sdlc_defines.svh
// Offsets, field positions, reset values and timing constants of the synthesizer control
`ifndef SDLC_DEFINES_SVH
`define SDLC_DEFINES_SVH

// Word indices on the register bus
`define SDLC_IDX_NDIV 2'h0
`define SDLC_IDX_OSC 2'h1
`define SDLC_IDX_STATUS 2'h2

// Control bits of a serial word select the target register
`define SDLC_CTRL_MSB 1
`define SDLC_CTRL_LSB 0
`define SDLC_CTRL_NDIV 2'h0
`define SDLC_CTRL_OSC 2'h1

// Feedback divider register fields
`define SDLC_FRAC_MSB 15
`define SDLC_FRAC_LSB 2
`define SDLC_INT_MSB 23
`define SDLC_INT_LSB 16
`define SDLC_LOOP_EN_BIT 28
`define SDLC_OBS_MSB 31
`define SDLC_OBS_LSB 29

// Oscillator register fields
`define SDLC_RDIV_MSB 4
`define SDLC_RDIV_LSB 2
`define SDLC_CLKDIV_MSB 11
`define SDLC_CLKDIV_LSB 8
`define SDLC_OSC_EN_BIT 12
`define SDLC_HALVE_BIT 13
`define SDLC_BIAS_MSB 19
`define SDLC_BIAS_LSB 16
`define SDLC_ADJ_MSB 21
`define SDLC_ADJ_LSB 20

// Power-up values: observe regulator ready, loop off; oscillator on, divide-by-8, R = 1
`define SDLC_NDIV_RST 32'h0000_0000
`define SDLC_OSC_RST 32'h0000_1404

// Status word bits
`define SDLC_ST_READY_BIT 0
`define SDLC_ST_DLOCK_BIT 1
`define SDLC_ST_CE_BIT 2
`define SDLC_ST_OSC_BIT 3

// Timing
`define SDLC_CLK_MHZ 250
`define SDLC_REG_READY_US 50
`define SDLC_REG_READY_CYC (`SDLC_REG_READY_US * `SDLC_CLK_MHZ)
`define SDLC_LOCK_SET_NS 8'h0F
`define SDLC_LOCK_CLR_NS 8'h19
`define SDLC_LOCK_RUN 3'h5

`endif

// >>> logic/sdlc_pkg.sv
// Types shared by the synthesizer control
package sdlc_pkg;
	typedef enum logic [2:0] {
		SDLC_OBS_REG_READY = 3'b000,
		SDLC_OBS_DLOCK = 3'b001,
		SDLC_OBS_ALOCK = 3'b010,
		SDLC_OBS_CMP_TICK = 3'b011,
		SDLC_OBS_DIV_REF = 3'b100,
		SDLC_OBS_FRAC_CARRY = 3'b101,
		SDLC_OBS_LOW = 3'b110,
		SDLC_OBS_HIGH = 3'b111
	} sdlc_obs_t;
endpackage

// >>> logic/sdlc_synth_ctrl.sv
// Synthesizer divider, lock detect and configuration control
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`include "sdlc_defines.svh"

module sdlc_synth_ctrl
	import sdlc_pkg::*;
#(
	parameter int REG_READY_CYC = `SDLC_REG_READY_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Chip enable pin
	input wire logic chip_enable,
	// Avalon-MM slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial configuration pins
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic word_commit_strobe,
	// Phase comparator measurement, one per comparison cycle
	input wire logic phase_err_valid,
	input wire logic [7:0] phase_err_ns,
	// Clock and loop outputs
	output logic osc_enable,
	output logic divided_ref_output,
	output logic cmp_tick,
	output logic [8:0] fb_divide,
	output logic vco_enable,
	output logic [3:0] vco_bias,
	output logic [1:0] vco_adjust,
	output logic out_halve,
	// Status outputs
	output logic observe_select_pin,
	output logic reg_ready,
	output logic digital_lock,
	output logic alock_o,
	output logic alock_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [1:0] ce_sync_reg;
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdat_sync_reg;
	logic [1:0] sle_sync_reg;
	logic sclk_last_reg;
	logic sle_last_reg;
	logic ce_on;

	// Two flip-flops on the chip enable and serial pins before use
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ce_sync_reg <= 2'h0;
			sclk_sync_reg <= 2'h0;
			sdat_sync_reg <= 2'h0;
			sle_sync_reg <= 2'h0;
			sclk_last_reg <= 1'b0;
			sle_last_reg <= 1'b0;
		end else begin
			ce_sync_reg <= {ce_sync_reg[0], chip_enable};
			sclk_sync_reg <= {sclk_sync_reg[0], ser_clk};
			sdat_sync_reg <= {sdat_sync_reg[0], ser_data};
			sle_sync_reg <= {sle_sync_reg[0], word_commit_strobe};
			sclk_last_reg <= sclk_sync_reg[1];
			sle_last_reg <= sle_sync_reg[1];
		end
	end

	assign ce_on = ce_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Regulator settling

	logic [$clog2(REG_READY_CYC+1)-1:0] ready_cnt_reg;
	logic ready_reg;

	// Counts settling time from chip enable; chip enable low drops the regulator
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ready_cnt_reg <= '0;
			ready_reg <= 1'b0;
		end else if (!ce_on) begin
			ready_cnt_reg <= '0;
			ready_reg <= 1'b0;
		end else if (ready_cnt_reg == ($clog2(REG_READY_CYC+1))'(REG_READY_CYC)) begin
			ready_reg <= 1'b1;
		end else begin
			ready_cnt_reg <= ready_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial word shifter

	logic [31:0] shift_reg;
	logic sclk_rise;
	logic sle_rise;

	assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
	assign sle_rise = sle_sync_reg[1] & ~sle_last_reg;

	// Bits arrive MSB first, so each new bit enters at the bottom
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_reg <= 32'h0000_0000;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[30:0], sdat_sync_reg[1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave handshake

	logic bus_req;
	logic bus_take;
	logic [31:0] ndiv_reg;
	logic [31:0] osc_reg;
	logic dlock_reg;

	assign bus_req = avs_read | avs_write;
	// Request completes at the edge where waitrequest is sampled low
	assign bus_take = bus_req & ~avs_waitrequest;

	// One wait cycle, then a single low cycle per request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
		end
	end

	// Read data loaded during the wait cycle, stands at the completing edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & avs_waitrequest) begin
			case (avs_address)
				`SDLC_IDX_NDIV: avs_readdata <= ndiv_reg;
				`SDLC_IDX_OSC: avs_readdata <= osc_reg;
				`SDLC_IDX_STATUS: begin
					avs_readdata <= 32'h0000_0000;
					avs_readdata[`SDLC_ST_READY_BIT] <= ready_reg;
					avs_readdata[`SDLC_ST_DLOCK_BIT] <= dlock_reg;
					avs_readdata[`SDLC_ST_CE_BIT] <= ce_on;
					avs_readdata[`SDLC_ST_OSC_BIT] <= osc_enable;
				end
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic bus_wr_ndiv;
	logic bus_wr_osc;
	logic ser_wr_ndiv;
	logic ser_wr_osc;

	// Writes count only once the regulator has settled
	assign bus_wr_ndiv = bus_take & avs_write & ready_reg & (avs_address == `SDLC_IDX_NDIV);
	assign bus_wr_osc = bus_take & avs_write & ready_reg & (avs_address == `SDLC_IDX_OSC);
	assign ser_wr_ndiv = sle_rise & ready_reg &
		(shift_reg[`SDLC_CTRL_MSB:`SDLC_CTRL_LSB] == `SDLC_CTRL_NDIV);
	assign ser_wr_osc = sle_rise & ready_reg &
		(shift_reg[`SDLC_CTRL_MSB:`SDLC_CTRL_LSB] == `SDLC_CTRL_OSC);

	// Feedback divider register; cleared to power-up value while chip enable is low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ndiv_reg <= `SDLC_NDIV_RST;
		end else if (!ce_on) begin
			ndiv_reg <= `SDLC_NDIV_RST;
		end else if (ser_wr_ndiv) begin
			ndiv_reg <= shift_reg;
		end else if (bus_wr_ndiv) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i]) begin
					ndiv_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
			end
		end
	end

	// Oscillator register; power-up value gives oscillator on, divide-by-8, R = 1
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_reg <= `SDLC_OSC_RST;
		end else if (!ce_on) begin
			osc_reg <= `SDLC_OSC_RST;
		end else if (ser_wr_osc) begin
			osc_reg <= shift_reg;
		end else if (bus_wr_osc) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i]) begin
					osc_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Static controls

	// Oscillator, loop and output stage settings
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_enable <= 1'b0;
			vco_enable <= 1'b0;
			vco_bias <= 4'h0;
			vco_adjust <= 2'h0;
			out_halve <= 1'b0;
			reg_ready <= 1'b0;
		end else begin
			osc_enable <= ce_on & osc_reg[`SDLC_OSC_EN_BIT];
			vco_enable <= ce_on & ndiv_reg[`SDLC_LOOP_EN_BIT];
			vco_bias <= osc_reg[`SDLC_BIAS_MSB:`SDLC_BIAS_LSB];
			vco_adjust <= osc_reg[`SDLC_ADJ_MSB:`SDLC_ADJ_LSB];
			out_halve <= osc_reg[`SDLC_HALVE_BIT];
			reg_ready <= ready_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Divided reference output

	logic [3:0] clkdiv;
	logic [3:0] half_cnt_reg;

	assign clkdiv = osc_reg[`SDLC_CLKDIV_MSB:`SDLC_CLKDIV_LSB];

	// Toggles every clkdiv cycles: ratio 2*clkdiv with equal halves; zero holds it low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			half_cnt_reg <= 4'h0;
			divided_ref_output <= 1'b0;
		end else if (clkdiv == 4'h0 || !osc_enable) begin
			half_cnt_reg <= 4'h0;
			divided_ref_output <= 1'b0;
		end else if (half_cnt_reg >= clkdiv - 4'h1) begin
			half_cnt_reg <= 4'h0;
			divided_ref_output <= ~divided_ref_output;
		end else begin
			half_cnt_reg <= half_cnt_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference divider for the phase comparator

	logic [2:0] rdiv;
	logic [2:0] rdiv_cnt_reg;

	// A zero field is taken as divide-by-one
	assign rdiv = (osc_reg[`SDLC_RDIV_MSB:`SDLC_RDIV_LSB] == 3'h0) ? 3'h1 :
		osc_reg[`SDLC_RDIV_MSB:`SDLC_RDIV_LSB];

	// One tick every rdiv reference cycles
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdiv_cnt_reg <= 3'h0;
			cmp_tick <= 1'b0;
		end else if (!osc_enable) begin
			rdiv_cnt_reg <= 3'h0;
			cmp_tick <= 1'b0;
		end else if (rdiv_cnt_reg >= rdiv - 3'h1) begin
			rdiv_cnt_reg <= 3'h0;
			cmp_tick <= 1'b1;
		end else begin
			rdiv_cnt_reg <= rdiv_cnt_reg + 3'h1;
			cmp_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fractional feedback divider

	logic [14:0] frac_acc_reg;
	logic [15:0] frac_sum;
	logic frac_carry_reg;

	// First-order accumulator over 2^15; carry adds one to the integer this cycle
	assign frac_sum = {1'b0, frac_acc_reg} + {2'h0, ndiv_reg[`SDLC_FRAC_MSB:`SDLC_FRAC_LSB]};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frac_acc_reg <= 15'h0000;
			frac_carry_reg <= 1'b0;
			fb_divide <= 9'h000;
		end else if (!vco_enable) begin
			frac_acc_reg <= 15'h0000;
			frac_carry_reg <= 1'b0;
			fb_divide <= {1'b0, ndiv_reg[`SDLC_INT_MSB:`SDLC_INT_LSB]};
		end else if (cmp_tick) begin
			frac_acc_reg <= frac_sum[14:0];
			frac_carry_reg <= frac_sum[15];
			fb_divide <= {1'b0, ndiv_reg[`SDLC_INT_MSB:`SDLC_INT_LSB]} +
				{8'h00, frac_sum[15]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lock detect

	logic [2:0] good_run_reg;

	// Five straight small errors set lock; one large error clears it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			good_run_reg <= 3'h0;
			dlock_reg <= 1'b0;
		end else if (!vco_enable) begin
			good_run_reg <= 3'h0;
			dlock_reg <= 1'b0;
		end else if (phase_err_valid) begin
			if (phase_err_ns < `SDLC_LOCK_SET_NS) begin
				if (good_run_reg >= `SDLC_LOCK_RUN - 3'h1) begin
					dlock_reg <= 1'b1;
				end else begin
					good_run_reg <= good_run_reg + 3'h1;
				end
			end else begin
				good_run_reg <= 3'h0;
			end
			if (phase_err_ns >= `SDLC_LOCK_CLR_NS) begin
				dlock_reg <= 1'b0;
			end
		end
	end

	// Open-drain analog lock: released while locked, pulled low on each nonzero error
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			digital_lock <= 1'b0;
			alock_o <= 1'b0;
			alock_oe <= 1'b1;
		end else begin
			digital_lock <= dlock_reg;
			alock_o <= 1'b0;
			alock_oe <= ~dlock_reg | (phase_err_valid & (phase_err_ns != 8'h00));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Observe multiplexer

	sdlc_obs_t obs_sel;

	assign obs_sel = sdlc_obs_t'(ndiv_reg[`SDLC_OBS_MSB:`SDLC_OBS_LSB]);

	// Routes the selected internal point to the observe pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			observe_select_pin <= 1'b0;
		end else begin
			case (obs_sel)
				SDLC_OBS_REG_READY: observe_select_pin <= ready_reg;
				SDLC_OBS_DLOCK: observe_select_pin <= dlock_reg;
				SDLC_OBS_ALOCK: observe_select_pin <= ~alock_oe;
				SDLC_OBS_CMP_TICK: observe_select_pin <= cmp_tick;
				SDLC_OBS_DIV_REF: observe_select_pin <= divided_ref_output;
				SDLC_OBS_FRAC_CARRY: observe_select_pin <= frac_carry_reg;
				SDLC_OBS_LOW: observe_select_pin <= 1'b0;
				SDLC_OBS_HIGH: observe_select_pin <= 1'b1;
				default: observe_select_pin <= 1'b0;
			endcase
		end
	end

endmodule

// >>> sim/sdlc_synth_ctrl_asserts.sv
// Port assertions for the synthesizer control
module sdlc_synth_ctrl_asserts #(
	parameter int REG_READY_CYC = 12500
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Watched ports
	input wire logic chip_enable,
	input wire logic phase_err_valid,
	input wire logic [7:0] phase_err_ns,
	input wire logic osc_enable,
	input wire logic divided_ref_output,
	input wire logic vco_enable,
	input wire logic [3:0] vco_bias,
	input wire logic out_halve,
	input wire logic reg_ready,
	input wire logic digital_lock,
	input wire logic alock_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	int ce_cnt_reg;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	////////////////////
	// Cycles since chip enable went high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ce_cnt_reg <= 0;
		end else begin
			ce_cnt_reg <= chip_enable ? ce_cnt_reg + 1 : 0;
		end
	end
	// Power-down clears the enables, ready, lock, bias and output halving
	property p_pwr_down;
		!chip_enable [*6] |-> !osc_enable && !vco_enable && !reg_ready && !digital_lock
			&& vco_bias == 4'h0 && !out_halve;
	endproperty
	a_pwr_down: assert property (p_pwr_down) else $error("state kept in power-down");
	property p_ref_off;
		!osc_enable [*2] |-> !divided_ref_output;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("clock out with osc off");
	property p_ready_late;
		chip_enable && ce_cnt_reg == REG_READY_CYC + 10 |-> reg_ready;
	endproperty
	a_ready_late: assert property (p_ready_late) else $error("ready too late");
	property p_ready_early;
		$rose(reg_ready) |-> ce_cnt_reg >= REG_READY_CYC;
	endproperty
	a_ready_early: assert property (p_ready_early) else $error("ready too early");
	property p_lock_set;
		$rose(digital_lock) |-> $past(phase_err_valid, 2) && $past(phase_err_ns, 2) < 8'h0F;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock without good sample");
	property p_lock_clear;
		phase_err_valid && phase_err_ns >= 8'h19 |-> ##2 !digital_lock;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock kept on big error");
	property p_lock_hold;
		$fell(digital_lock) |-> !vco_enable || !$past(vco_enable)
			|| ($past(phase_err_valid, 2) && $past(phase_err_ns, 2) >= 8'h19);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock lost early");
	// Lock level and pull-down both follow the same internal lock state
	property p_alock;
		!digital_lock |-> alock_oe;
	endproperty
	a_alock: assert property (p_alock) else $error("analog lock released unlocked");
	property p_alock_free;
		digital_lock && !phase_err_valid |=> !alock_oe || !digital_lock;
	endproperty
	a_alock_free: assert property (p_alock_free) else $error("analog lock held low");
	// Main scenarios
	c_lock: cover property ($rose(digital_lock));
	c_ready: cover property ($rose(reg_ready));
	c_unlock: cover property ($fell(digital_lock));
endmodule

bind sdlc_synth_ctrl sdlc_synth_ctrl_asserts #(.REG_READY_CYC(REG_READY_CYC))
	sdlc_synth_ctrl_asserts_i (.core_clk, .rst, .chip_enable, .phase_err_valid,
	.phase_err_ns, .osc_enable, .divided_ref_output, .vco_enable, .vco_bias, .out_halve,
	.reg_ready, .digital_lock, .alock_oe);

// >>> sim/sdlc_host_model.sv
// Host model that shifts configuration words into the serial pins
module sdlc_host_model (
	// Clock
	input wire logic core_clk,
	// Word request from the bench
	input wire logic go,
	input wire logic [31:0] word,
	input wire logic [3:0] hold,
	output logic done,
	// Regulator status seen by the host
	input wire logic reg_ready,
	// Serial pins
	output logic ser_clk,
	output logic ser_data,
	output logic word_commit_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{done, ser_clk, ser_data, word_commit_strobe} = 4'h0;
	end
	////////////////////
	// Every pin level stands for hold cycles, three or more
	always @(posedge core_clk) begin
		if (!go) begin
			done <= 1'b0;
		end else if (!done && reg_ready) begin
			for (int i = 31; i >= 0; i--) begin
				ser_data <= word[i];
				repeat (hold) @(posedge core_clk);
				ser_clk <= 1'b1;
				repeat (hold) @(posedge core_clk);
				ser_clk <= 1'b0;
			end
			repeat (hold) @(posedge core_clk);
			word_commit_strobe <= 1'b1;
			ser_data <= ~ser_data; // Idle line shows no stale bit
			repeat (hold) @(posedge core_clk);
			word_commit_strobe <= 1'b0;
			done <= 1'b1;
		end
	end
endmodule

// >>> sim/sdlc_synth_ctrl_tb_top.sv
// Self-checking bench for the synthesizer control
module sdlc_synth_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, chip_enable, avs_read, avs_write, avs_waitrequest, go, done;
	logic ser_clk, ser_data, word_commit_strobe, phase_err_valid, cmp_tick, osc_enable;
	logic divided_ref_output, vco_enable, out_halve, observe_select_pin, reg_ready;
	logic digital_lock, alock_o, alock_oe;
	logic [1:0] avs_address, vco_adjust;
	logic [3:0] vco_bias, hold;
	logic [7:0] phase_err_ns;
	logic [8:0] fb_divide;
	logic [31:0] avs_writedata, avs_readdata, pv, w;
	logic [31:0] q[$];
	logic [3:0] fl[4] = '{4'h1, 4'h5, 4'hF, 4'h0};
	logic [2:0] rl[4] = '{3'h7, 3'h0, 3'h5, 3'h1};
	int miscompares, checked, n, k, seed;
	event pe;

	sdlc_synth_ctrl #(.REG_READY_CYC(20)) sdlc_synth_ctrl_i (.core_clk, .rst, .chip_enable,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
		.avs_readdata, .avs_waitrequest, .ser_clk, .ser_data, .word_commit_strobe,
		.phase_err_valid, .phase_err_ns, .osc_enable, .divided_ref_output, .cmp_tick,
		.fb_divide, .vco_enable, .vco_bias, .vco_adjust, .out_halve, .observe_select_pin,
		.reg_ready, .digital_lock, .alock_o, .alock_oe);
	sdlc_host_model sdlc_host_model_i (.core_clk, .go, .word(w), .hold, .done, .reg_ready,
		.ser_clk, .ser_data, .word_commit_strobe);
	////////////////////
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic finish_test;
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Match a result against the oldest expectation
	task automatic cmp(input logic [31:0] got);
		logic [31:0] e;
		e = q.pop_front();
		checked++;
		if (got !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask
	// Watch read completions and port probes
	always @(posedge core_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			cmp(avs_readdata);
		end
	end
	always @(pe) begin
		cmp(pv);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		q.push_back(exp);
		pv = got;
		->pe;
		// Next stimulus starts right after a rising edge
		@(posedge core_clk);
	endtask
	// Avalon cycle held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		q.push_back(exp);
		bus(1'b0, a, 32'h0);
		// Let the watcher take the read data before the next note is queued
		@(posedge core_clk);
	endtask
	// Config word by serial host or by bus, then settle
	task automatic put(input logic [31:0] x, input logic ser);
		if (ser) begin
			w <= x;
			go <= 1'b1;
			@(posedge core_clk);
			while (done !== 1'b1) @(posedge core_clk);
			go <= 1'b0;
		end else begin
			bus(1'b1, x[1:0], x);
		end
		repeat (40) @(posedge core_clk);
	endtask
	function automatic logic [31:0] osc_w(input logic [3:0] f, input logic [2:0] r,
		input logic h);
		return {10'h0, 2'h3, 4'hC, 2'h0, h, 1'b1, f, 3'h0, r, 2'h1};
	endfunction
	function automatic logic [31:0] div_w(input logic [2:0] s, input logic [7:0] i,
		input logic [13:0] fr);
		return {s, 1'b1, 4'h0, i, fr, 2'h0};
	endfunction
	// Count clock-out level, edges and comparison ticks over 840 cycles
	task automatic ref_run(input logic [3:0] f, input logic [2:0] r);
		int hi, tg, tk;
		logic p;
		{hi, tg, tk} = '0;
		p = divided_ref_output;
		repeat (840) begin
			@(posedge core_clk);
			hi += divided_ref_output;
			tg += (divided_ref_output !== p);
			tk += cmp_tick;
			p = divided_ref_output;
		end
		chk(32'(hi), f ? 32'h1A4 : 32'h0);
		chk(32'(tg), f ? 32'h348 / f : 32'h0);
		chk(32'(tk), 32'h348 / (r ? r : 3'h1));
	endtask
	task automatic ph(input logic [7:0] v);
		phase_err_valid <= 1'b1;
		phase_err_ns <= v;
		@(posedge core_clk);
		phase_err_valid <= 1'b0;
		phase_err_ns <= ~v;
		repeat (4) @(posedge core_clk);
	endtask
	// Main sequence
	initial begin
		seed = 32'h9813;
		{rst, chip_enable, avs_read, avs_write, go, phase_err_valid} = 6'h30;
		{avs_address, avs_writedata, phase_err_ns, w} = '0;
		hold = 4'h3;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd(2'h1, 32'h0000_1404);
		bus(1'b1, 2'h1, 32'h0);
		rd(2'h1, 32'h0000_1404);
		rd(2'h0, 32'h0);
		chk(32'(observe_select_pin), 32'h0);
		while (reg_ready !== 1'b1) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		chk(32'(observe_select_pin), 32'h1);
		ref_run(4'h4, 3'h1);
		for (int i = 0; i < 4; i++) begin
			hold <= i[1] ? 4'h6 : 4'h3;
			put(osc_w(fl[i], rl[i], i[0]), i[0]);
			chk(32'({vco_adjust, vco_bias, out_halve}), 32'({2'h3, 4'hC, i[0]}));
			ref_run(fl[i], rl[i]);
		end
		k = $unsigned($random(seed)) % 16;
		put(div_w(3'h7, 8'hFF, 14'(k << 10)), 1'b1);
		chk(32'({observe_select_pin, vco_enable}), 32'h3);
		n = 0;
		repeat (320) begin
			@(posedge core_clk);
			n += fb_divide;
		end
		chk(32'(n), 32'h13EC0 + 10 * k);
		put(div_w(3'h6, 8'h1F, 14'h0), 1'b0);
		chk(32'(observe_select_pin), 32'h0);
		put(div_w(3'h1, 8'h1F, 14'h0), 1'b0);
		for (int i = 0; i < 4; i++) ph(8'($unsigned($random(seed)) % 15));
		ph(8'h0F);
		chk(32'({digital_lock, observe_select_pin}), 32'h0);
		ph(8'h0E);
		for (int i = 0; i < 4; i++) ph(8'($unsigned($random(seed)) % 15));
		chk(32'({digital_lock, observe_select_pin}), 32'h3);
		ph(8'h18);
		chk(32'({digital_lock, alock_o, alock_oe}), 32'h4);
		rd(2'h2, 32'hF);
		ph(8'h19);
		chk(32'({digital_lock, observe_select_pin}), 32'h0);
		rd(2'h3, 32'h0);
		chip_enable <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk(32'({osc_enable, vco_enable, reg_ready, vco_bias}), 32'h0);
		rd(2'h0, 32'h0);
		chip_enable <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk(32'({osc_enable, reg_ready}), 32'h2);
		rd(2'h1, 32'h0000_1404);
		finish_test();
	end
	// Watchdog
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		finish_test();
	end
endmodule
